// [common/temp_monitor_pkg.sv]
/*
 * Shared constants for the temperature monitor: register map, config and
 * status fields, sequencer and bus states, timing counts.
 * Assumes a 200 MHz system clock.
 */
package temp_monitor_pkg;
  localparam int CLK_MHZ = 200;
  // register map
  localparam logic [7:0] R_LOC_VAL  = 8'h00;
  localparam logic [7:0] R_REM_HI   = 8'h01;
  localparam logic [7:0] R_STATUS   = 8'h02;
  localparam logic [7:0] R_CFG_RD   = 8'h03;
  localparam logic [7:0] R_RATE     = 8'h04;
  localparam logic [7:0] R_CFG_WR   = 8'h09;
  localparam logic [7:0] R_ONE_SHOT = 8'h0f;
  localparam logic [7:0] R_REM_LO   = 8'h10;
  // limit slots: loc high, loc low, rem high hi/lo, rem low hi/lo, therms
  localparam int LIM_N = 8;
  localparam logic [7:0] LIM_ADDR [LIM_N] =
    '{8'h05, 8'h06, 8'h07, 8'h13, 8'h08, 8'h14, 8'h20, 8'h19};
  localparam logic [7:0] LIM_RESET [LIM_N] =
    '{8'h7f, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h7f};
  localparam int L_LOC_HIGH = 0;
  localparam int L_LOC_LOW  = 1;
  localparam int L_REM_HH   = 2;
  localparam int L_REM_HL   = 3;
  localparam int L_REM_LH   = 4;
  localparam int L_REM_LL   = 5;
  localparam int L_LOC_TH   = 6;
  localparam int L_REM_TH   = 7;
  // config fields
  localparam int CFG_MASK    = 7;
  localparam int CFG_STANDBY = 6;
  localparam int CFG_PIN2    = 5;
  localparam int CFG_EXT     = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'he4;
  // status fields
  localparam int ST_BUSY = 7;
  localparam int ST_LHI  = 6;
  localparam int ST_LLO  = 5;
  localparam int ST_RHI  = 4;
  localparam int ST_RLO  = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_RTH  = 1;
  localparam int ST_LTH  = 0;
  // rate codes: 0 is 1/16 per s, each step doubles, 8 is 16 per s
  localparam logic [3:0] RATE_RESET = 4'h7;
  localparam logic [3:0] RATE_MAX   = 4'ha;
  localparam logic [3:0] RATE_FAST  = 4'h8;
  localparam logic [3:0] AVG_LAST   = 4'hf;
  // converter word: signed quarter degrees
  localparam int ADC_W = 13;
  localparam logic signed [13:0] EXT_OFS_Q = 14'sh0100;
  localparam logic signed [13:0] MAX_BIN_Q = 14'sh01ff;
  localparam logic signed [13:0] MAX_EXT_Q = 14'sh03ff;
  // timing
  localparam longint ONESHOT_AVG_US = 52000;
  localparam longint ONESHOT_RAW_US = 8000;
  localparam longint CONV_BASE_MS   = 16000;
  localparam longint ONESHOT_AVG_CYC = ONESHOT_AVG_US * CLK_MHZ;
  localparam longint ONESHOT_RAW_CYC = ONESHOT_RAW_US * CLK_MHZ;
  localparam longint CONV_BASE_CYC   = CONV_BASE_MS * CLK_MHZ * 1000;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_LOCAL = 4'b0010,
    S_REM_N1 = 4'b0100, S_REM_N2 = 4'b1000
  } seq_state_t;
  typedef enum logic [6:0] {
    B_IDLE = 7'b0000001, B_ADDR = 7'b0000010, B_ACK_A = 7'b0000100,
    B_WR = 7'b0001000, B_ACK_W = 7'b0010000, B_RD = 7'b0100000,
    B_ACK_R = 7'b1000000
  } bus_state_t;
endpackage : temp_monitor_pkg

// [common/smbus_reg_if.sv]
/*
 * Carrier between the serial slave and the register file.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface smbus_reg_if;
  logic [7:0] ptr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output ptr, output wr, output rd, output wdata,
                 input rdata);
  modport regs (input ptr, input wr, input rd, input wdata,
                output rdata);
endinterface : smbus_reg_if

// [hdl/smbus_slave.sv]
/*
 * Two-wire serial slave: address match, pointer byte, data writes,
 * single-register reads repeated until the host stops acking.
 * Assumes scl and sda already synchronous to clk; no clock stretching.
 */
`timescale 1ns/1ps
module smbus_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  output logic        sda_oe_n,
  smbus_reg_if.slave  rb
);
  temp_monitor_pkg::bus_state_t st_r;
  logic       scl_q, sda_q, rw_r, first_r, ack_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r;
  logic       start, stop, rise, fall;

  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;
  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= temp_monitor_pkg::B_IDLE;
      sda_oe_n <= 1'b1;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      ack_r <= 1'b0;
      rb.ptr <= 8'h00;
      rb.wr <= 1'b0;
      rb.rd <= 1'b0;
      rb.wdata <= 8'h00;
    end else begin
      rb.wr <= 1'b0;
      rb.rd <= 1'b0;
      if (start) begin
        st_r <= temp_monitor_pkg::B_ADDR;
        cnt_r <= 4'h0;
        first_r <= 1'b1;
        sda_oe_n <= 1'b1;
      end else if (stop) begin
        st_r <= temp_monitor_pkg::B_IDLE;
        sda_oe_n <= 1'b1;
      end else if (rise) begin
        if (st_r == temp_monitor_pkg::B_ADDR ||
            st_r == temp_monitor_pkg::B_WR) begin
          sh_r <= {sh_r[6:0], sda_i};
          cnt_r <= cnt_r + 4'h1;
        end
        if (st_r == temp_monitor_pkg::B_RD) cnt_r <= cnt_r + 4'h1;
        if (st_r == temp_monitor_pkg::B_ACK_R) ack_r <= ~sda_i;
      end else if (fall) begin
        unique case (st_r)
          temp_monitor_pkg::B_ADDR: begin
            if (cnt_r == 4'h8) begin
              if (sh_r[7:1] == DEV_ADDR) begin
                sda_oe_n <= 1'b0;
                rw_r <= sh_r[0];
                st_r <= temp_monitor_pkg::B_ACK_A;
              end else st_r <= temp_monitor_pkg::B_IDLE;
            end
          end
          temp_monitor_pkg::B_ACK_A, temp_monitor_pkg::B_ACK_R: begin
            cnt_r <= 4'h0;
            if ((st_r == temp_monitor_pkg::B_ACK_A && rw_r) ||
                (st_r == temp_monitor_pkg::B_ACK_R && ack_r)) begin
              // reads fetch at this edge; side effects follow a cycle on
              tx_r <= rb.rdata;
              rb.rd <= 1'b1;
              sda_oe_n <= rb.rdata[7];
              st_r <= temp_monitor_pkg::B_RD;
            end else begin
              sda_oe_n <= 1'b1;
              st_r <= rw_r ? temp_monitor_pkg::B_IDLE
                           : temp_monitor_pkg::B_WR;
            end
          end
          temp_monitor_pkg::B_WR: begin
            if (cnt_r == 4'h8) begin
              sda_oe_n <= 1'b0;
              st_r <= temp_monitor_pkg::B_ACK_W;
              first_r <= 1'b0;
              if (first_r) rb.ptr <= sh_r;
              else begin
                rb.wr <= 1'b1;
                rb.wdata <= sh_r;
              end
            end
          end
          temp_monitor_pkg::B_ACK_W: begin
            sda_oe_n <= 1'b1;
            cnt_r <= 4'h0;
            st_r <= temp_monitor_pkg::B_WR;
          end
          temp_monitor_pkg::B_RD: begin
            if (cnt_r == 4'h8) begin
              sda_oe_n <= 1'b1;
              st_r <= temp_monitor_pkg::B_ACK_R;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_n <= tx_r[6];
            end
          end
          temp_monitor_pkg::B_IDLE: ;
        endcase
      end
    end
  end
endmodule : smbus_slave

// [hdl/temp_monitor.sv]
/*
 * Digital side of a two-channel temperature monitor: conversion sequencer,
 * averaging, value and limit registers, status flags, alarm and thermal pins.
 * Assumes an external converter returning signed quarter degrees per step.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - converter runs freely, alternating local and remote, storing results.
// - each result is compared with its high, low and thermal limits.
// - every out-of-limit outcome sets its own status flag.
// - alarm pin goes low on high or low limit crossing.
// - a remote diode fault also pulls the alarm pin low.
// - thermal pin goes low while a result exceeds its thermal limit.
// - config may turn the alarm pin into a second thermal pin.
// - host writes limits and config, reads back any register.
// - config holds standby, range, alarm mask and pin mode; rate has its own register.
// - remote step biases base against first, then second multiple.
// - at low rates each result is the mean of sixteen cycles.
// - at sixteen per second and faster, single results pass directly.
// - one-shot ends within 52 ms averaged, 8 ms unaveraged.
// - local result sits at 0x00 in whole degrees.
// - remote result: integer byte at 0x01, fraction byte at 0x10.
// - only top two bits of remote low byte carry data.
// - fraction bits give quarter degrees 0.00 to 0.75.
// - low byte read freezes high byte until the host reads it.
// - config bit 7 masks the alarm, ignored in second thermal mode.
// - config bit 2 selects extended offset-binary range.
module temp_monitor #(
  parameter logic [6:0]  DEV_ADDR    = 7'h48,
  parameter int unsigned AVG_BUDGET  = 32'(temp_monitor_pkg::ONESHOT_AVG_CYC),
  parameter int unsigned RAW_BUDGET  = 32'(temp_monitor_pkg::ONESHOT_RAW_CYC),
  parameter int unsigned CONV_BASE   = 32'(temp_monitor_pkg::CONV_BASE_CYC)
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic             adc_start,
  output logic             adc_remote,
  output logic             adc_bias_n2,
  input  wire logic        adc_done,
  input  wire logic [12:0] adc_temp,
  input  wire logic        diode_fault,
  output logic             alarm_o,
  output logic             alarm_oe_n,
  output logic             thermal_trip_out_n_o,
  output logic             thermal_trip_out_n_oe_n
);
  smbus_reg_if rb ();

  logic [7:0] cfg_r, status_r, status_q, local_temp_value_r;
  logic [7:0] remote_temp_high_byte_r, remote_temp_low_byte_r;
  logic [7:0] lim_r [temp_monitor_pkg::LIM_N];
  logic [3:0] rate_r, meas_cnt_r;
  logic       lock_r, shot_req_r, shot_run_r, zero_r;
  logic       lhi_x, llo_x, lth_x, rhi_x, rlo_x, rth_x;
  logic [31:0] period_r, budget_r;
  logic signed [16:0] acc_loc_r, acc_rem_r, sum;
  temp_monitor_pkg::seq_state_t st_r;
  logic       avg_on, last, tick, go, loc_commit, rem_commit, timeout;
  logic [3:0] rate_eff;
  logic signed [12:0] result;
  logic [9:0] f;
  logic [9:0] rem_hlim, rem_llim;

  smbus_slave #(.DEV_ADDR(DEV_ADDR)) u_bus (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_oe_n (sda_oe_n),
    .rb       (rb.slave)
  );

  // offset for the extended range, then clamp
  function automatic logic [9:0] fmt(input logic signed [12:0] q,
                                     input logic ext);
    logic signed [13:0] v;
    v = {q[12], q} + (ext ? temp_monitor_pkg::EXT_OFS_Q : 14'sh0000);
    if (v < 14'sh0000) v = 14'sh0000;
    if (!ext && v > temp_monitor_pkg::MAX_BIN_Q)
      v = temp_monitor_pkg::MAX_BIN_Q;
    if (ext && v > temp_monitor_pkg::MAX_EXT_Q)
      v = temp_monitor_pkg::MAX_EXT_Q;
    return v[9:0];
  endfunction : fmt

  ////////////////////////////////////////////////////////////////////////
  // host registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= temp_monitor_pkg::CFG_RESET;
      rate_r <= temp_monitor_pkg::RATE_RESET;
      for (int i = 0; i < temp_monitor_pkg::LIM_N; i++)
        lim_r[i] <= temp_monitor_pkg::LIM_RESET[i];
    end else if (rb.wr) begin
      if (rb.ptr == temp_monitor_pkg::R_CFG_WR)
        cfg_r <= rb.wdata & temp_monitor_pkg::CFG_WMASK;
      if (rb.ptr == temp_monitor_pkg::R_RATE)
        rate_r <= rb.wdata[3:0];
      for (int i = 0; i < temp_monitor_pkg::LIM_N; i++)
        if (rb.ptr == temp_monitor_pkg::LIM_ADDR[i])
          lim_r[i] <= rb.wdata;
    end
  end

  always_comb begin
    rb.rdata = 8'h00;
    unique case (rb.ptr)
      temp_monitor_pkg::R_LOC_VAL: rb.rdata = local_temp_value_r;
      temp_monitor_pkg::R_REM_HI:
        rb.rdata = remote_temp_high_byte_r;
      temp_monitor_pkg::R_REM_LO:
        rb.rdata = remote_temp_low_byte_r;
      temp_monitor_pkg::R_STATUS:  rb.rdata = status_r;
      temp_monitor_pkg::R_CFG_RD:  rb.rdata = cfg_r;
      temp_monitor_pkg::R_RATE:    rb.rdata = {4'h0, rate_r};
      default: begin
        for (int i = 0; i < temp_monitor_pkg::LIM_N; i++)
          if (rb.ptr == temp_monitor_pkg::LIM_ADDR[i])
            rb.rdata = lim_r[i];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion pacing
  assign rate_eff = (rate_r > temp_monitor_pkg::RATE_MAX) ?
                    temp_monitor_pkg::RATE_MAX : rate_r;
  assign avg_on = rate_eff < temp_monitor_pkg::RATE_FAST;
  assign tick = (period_r == 32'h0) & ~cfg_r[temp_monitor_pkg::CFG_STANDBY];
  assign go = (st_r == temp_monitor_pkg::S_IDLE) & (tick | shot_req_r);
  assign timeout = shot_run_r &
                   (budget_r >= (avg_on ? AVG_BUDGET : RAW_BUDGET));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) period_r <= 32'h0;
    else if (cfg_r[temp_monitor_pkg::CFG_STANDBY]) period_r <= 32'h0;
    else if (period_r == 32'h0) period_r <= (CONV_BASE >> rate_eff) - 1;
    else period_r <= period_r - 32'h1;
  end

  // one-shot: requested by a write, policed by a cycle budget
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shot_req_r <= 1'b0;
      shot_run_r <= 1'b0;
      budget_r <= 32'h0;
    end else begin
      if (rb.wr && rb.ptr == temp_monitor_pkg::R_ONE_SHOT)
        shot_req_r <= 1'b1;
      else if (go) shot_req_r <= 1'b0;
      if (go && !tick) begin
        shot_run_r <= 1'b1;
        budget_r <= 32'h0;
      end else if (st_r == temp_monitor_pkg::S_IDLE || timeout)
        shot_run_r <= 1'b0;
      else if (shot_run_r) budget_r <= budget_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: local step, then two remote bias steps
  assign last = !avg_on || meas_cnt_r == temp_monitor_pkg::AVG_LAST;
  assign sum = (st_r == temp_monitor_pkg::S_LOCAL ? acc_loc_r : acc_rem_r)
               + {{4{adc_temp[12]}}, adc_temp};
  assign result = avg_on ? sum[16:4] : adc_temp;
  assign f = fmt(result, cfg_r[temp_monitor_pkg::CFG_EXT]);
  assign loc_commit = adc_done & last & (st_r == temp_monitor_pkg::S_LOCAL);
  assign rem_commit = adc_done & last & (st_r == temp_monitor_pkg::S_REM_N2);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= temp_monitor_pkg::S_IDLE;
      adc_start <= 1'b0;
      adc_remote <= 1'b0;
      adc_bias_n2 <= 1'b0;
      meas_cnt_r <= 4'h0;
      acc_loc_r <= 17'sh0;
      acc_rem_r <= 17'sh0;
    end else begin
      adc_start <= 1'b0;
      if (timeout) st_r <= temp_monitor_pkg::S_IDLE;
      else unique case (st_r)
        temp_monitor_pkg::S_IDLE: if (go) begin
          meas_cnt_r <= 4'h0;
          acc_loc_r <= 17'sh0;
          acc_rem_r <= 17'sh0;
          adc_remote <= 1'b0;
          adc_bias_n2 <= 1'b0;
          adc_start <= 1'b1;
          st_r <= temp_monitor_pkg::S_LOCAL;
        end
        temp_monitor_pkg::S_LOCAL: if (adc_done) begin
          acc_loc_r <= sum;
          adc_remote <= 1'b1;
          adc_bias_n2 <= 1'b0;
          adc_start <= 1'b1;
          st_r <= temp_monitor_pkg::S_REM_N1;
        end
        temp_monitor_pkg::S_REM_N1: if (adc_done) begin
          adc_bias_n2 <= 1'b1;
          adc_start <= 1'b1;
          st_r <= temp_monitor_pkg::S_REM_N2;
        end
        temp_monitor_pkg::S_REM_N2: if (adc_done) begin
          acc_rem_r <= sum;
          adc_bias_n2 <= 1'b0;
          adc_remote <= 1'b0;
          if (last) st_r <= temp_monitor_pkg::S_IDLE;
          else begin
            meas_cnt_r <= meas_cnt_r + 4'h1;
            adc_start <= 1'b1;
            st_r <= temp_monitor_pkg::S_LOCAL;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // value registers and coherent remote read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      local_temp_value_r <= 8'h00;
      remote_temp_high_byte_r <= 8'h00;
      remote_temp_low_byte_r <= 8'h00;
      lock_r <= 1'b0;
    end else begin
      if (loc_commit) local_temp_value_r <= f[9:2];
      if (rem_commit && !diode_fault) begin
        remote_temp_low_byte_r <= {f[1:0], 6'h00};
        if (!lock_r) remote_temp_high_byte_r <= f[9:2];
      end
      if (rb.rd && rb.ptr == temp_monitor_pkg::R_REM_LO)
        lock_r <= 1'b1;
      else if (rb.rd && rb.ptr == temp_monitor_pkg::R_REM_HI)
        lock_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limit comparison, judged only at completion
  assign rem_hlim = {lim_r[temp_monitor_pkg::L_REM_HH],
                     lim_r[temp_monitor_pkg::L_REM_HL][7:6]};
  assign rem_llim = {lim_r[temp_monitor_pkg::L_REM_LH],
                     lim_r[temp_monitor_pkg::L_REM_LL][7:6]};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {lhi_x, llo_x, lth_x, rhi_x, rlo_x, rth_x} <= 6'h00;
    end else begin
      if (loc_commit) begin
        lhi_x <= f[9:2] > lim_r[temp_monitor_pkg::L_LOC_HIGH];
        llo_x <= f[9:2] < lim_r[temp_monitor_pkg::L_LOC_LOW];
        lth_x <= f[9:2] > lim_r[temp_monitor_pkg::L_LOC_TH];
      end
      if (rem_commit && !diode_fault) begin
        rhi_x <= f > rem_hlim;
        rlo_x <= f < rem_llim;
        rth_x <= f[9:2] > lim_r[temp_monitor_pkg::L_REM_TH];
      end
    end
  end

  // sticky flags, cleared by a status read; a set in that cycle wins
  logic [7:0] st_set, st_clr;
  always_comb begin
    st_set = 8'h00;
    st_set[temp_monitor_pkg::ST_LHI] = lhi_x;
    st_set[temp_monitor_pkg::ST_LLO] = llo_x;
    st_set[temp_monitor_pkg::ST_RHI] = rhi_x;
    st_set[temp_monitor_pkg::ST_RLO] = rlo_x;
    st_set[temp_monitor_pkg::ST_LTH] = lth_x;
    st_set[temp_monitor_pkg::ST_RTH] = rth_x;
    st_set[temp_monitor_pkg::ST_OPEN] = rem_commit & diode_fault;
    st_clr = (rb.rd && rb.ptr == temp_monitor_pkg::R_STATUS) ?
             status_q : 8'h00;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= 8'h00;
      status_q <= 8'h00;
    end else begin
      // status_q is what the slave fetched one cycle before the read pulse
      status_q <= status_r;
      status_r <= (status_r & ~st_clr) | st_set;
      status_r[temp_monitor_pkg::ST_BUSY] <=
        st_r != temp_monitor_pkg::S_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // open-drain pins: enable low pulls the wire low
  logic alert_on, second_trip_on, pin2_mode;
  assign pin2_mode = cfg_r[temp_monitor_pkg::CFG_PIN2];
  assign alert_on = |(status_r & 8'h7c) &
                    ~cfg_r[temp_monitor_pkg::CFG_MASK];
  assign second_trip_on = lhi_x | rhi_x;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_r <= 1'b0;
      alarm_oe_n <= 1'b1;
      thermal_trip_out_n_oe_n <= 1'b1;
    end else begin
      zero_r <= 1'b0;
      alarm_oe_n <= ~(pin2_mode ? second_trip_on : alert_on);
      thermal_trip_out_n_oe_n <= ~(lth_x | rth_x);
    end
  end

  assign sda_o = zero_r;
  assign alarm_o = zero_r;
  assign thermal_trip_out_n_o = zero_r;
endmodule : temp_monitor

// [tb/temp_monitor_chk.sv]
/* checker: converter step order and serial pin timing of temp_monitor.
   assumes only the top module's ports; bound at the foot. */
`timescale 1ns/1ps
module temp_monitor_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic adc_start,
  input wire logic adc_remote,
  input wire logic adc_bias_n2,
  input wire logic adc_done,
  input wire logic alarm_o,
  input wire logic alarm_oe_n,
  input wire logic thermal_trip_out_n_o,
  input wire logic thermal_trip_out_n_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start longer than one cycle");
  a_local_then_rem: assert property (adc_done && !adc_remote |=>
    adc_start && adc_remote && !adc_bias_n2)
    else $error("remote step does not follow local step");
  a_n2_follows: assert property (adc_done && adc_remote &&
    !adc_bias_n2 |=> adc_start && adc_bias_n2)
    else $error("second multiple does not follow first");
  a_rem_cause: assert property (adc_start && adc_remote &&
    !adc_bias_n2 |-> $past(adc_done) && !$past(adc_remote))
    else $error("first multiple without local step before");
  a_bias_cause: assert property (adc_start && adc_bias_n2 |->
    adc_remote && $past(adc_done) && !$past(adc_bias_n2))
    else $error("second multiple out of order");
  a_ctrl_steady: assert property (!adc_start && !$past(adc_done) |->
    $stable({adc_remote, adc_bias_n2}))
    else $error("step selects moved mid step");
  a_drive_low: assert property (!sda_o && !alarm_o &&
    !thermal_trip_out_n_o)
    else $error("open drain data not low");
  a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_i)
    else $error("sda pulled while scl high");
  a_sda_hold: assert property (scl_i && $past(scl_i) |->
    $stable(sda_oe_n))
    else $error("sda moved while scl high");
  c_alarm: cover property (!alarm_oe_n);
  c_thermal: cover property (!thermal_trip_out_n_oe_n);
  c_remote: cover property (adc_done && adc_bias_n2);
endmodule : temp_monitor_chk

bind temp_monitor temp_monitor_chk i_temp_monitor_chk (.clk, .sys_rst,
  .scl_i, .sda_o, .sda_oe_n, .adc_start, .adc_remote, .adc_bias_n2,
  .adc_done, .alarm_o, .alarm_oe_n, .thermal_trip_out_n_o,
  .thermal_trip_out_n_oe_n);

// [tb/smbus_host_model.sv]
/* serial host: pointer write, register write, single-byte read.
   assumes the bench resolves the open-drain data wire. */
`timescale 1ns/1ps
module smbus_host_model #(
  parameter logic [6:0] ADDR = 7'h48
) (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_rel
);
  int nak_cnt = 0;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask : hc
  // bit changes only while scl is low
  task automatic bit_x(input logic b, output logic r);
    sda_rel = b;
    hc(2);
    scl = 1'b1;
    hc(2);
    r = sda_wire;
    hc(2);
    scl = 1'b0;
    hc(2);
  endtask : bit_x
  task automatic start_c();
    sda_rel = 1'b1;
    scl = 1'b1;
    hc(2);
    sda_rel = 1'b0;
    hc(2);
    scl = 1'b0;
    hc(2);
  endtask : start_c
  task automatic stop_c();
    sda_rel = 1'b0;
    hc(2);
    scl = 1'b1;
    hc(2);
    sda_rel = 1'b1;
    hc(4);
  endtask : stop_c
  // rd: host releases data and answers no-ack
  task automatic xfer(input logic [7:0] d, input logic rd,
                      output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(rd | d[i], q[i]);
    bit_x(1'b1, r);
    if (!rd && r) nak_cnt++;
  endtask : xfer
  task automatic write_reg(input logic [7:0] a, d, input logic data);
    logic [7:0] q;
    start_c();
    xfer({ADDR, 1'b0}, 1'b0, q);
    xfer(a, 1'b0, q);
    if (data) xfer(d, 1'b0, q);
    stop_c();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    write_reg(a, 8'h00, 1'b0);
    start_c();
    xfer({ADDR, 1'b1}, 1'b0, q);
    xfer(8'hff, 1'b1, q);
    stop_c();
  endtask : read_reg
endmodule : smbus_host_model

// [tb/temp_monitor_results_tb_top.sv]
/* bench for temp_monitor: host model on the serial pins and a converter
   stand-in answering each step two cycles after its start. */
`timescale 1ns/1ps
module temp_monitor_results_tb_top;
  logic        clk, sys_rst, sda_o, sda_oe_n, adc_start, adc_remote;
  logic        adc_bias_n2, adc_done, diode_fault, alarm_o, alarm_oe_n;
  logic        th_o, th_oe_n, scl, sda_rel;
  logic [12:0] adc_temp, loc_q, rem_q;
  logic [1:0]  pend;
  logic [7:0]  q;
  int          error_cnt = 0;
  int          total_checks = 0;
  wire         sda_wire = sda_oe_n & sda_rel;
  temp_monitor #(.AVG_BUDGET(2000), .RAW_BUDGET(200), .CONV_BASE(4096))
  i_temp_monitor (.clk, .sys_rst, .scl_i(scl), .sda_i(sda_wire), .sda_o,
    .sda_oe_n, .adc_start, .adc_remote, .adc_bias_n2, .adc_done,
    .adc_temp, .diode_fault, .alarm_o, .alarm_oe_n,
    .thermal_trip_out_n_o(th_o), .thermal_trip_out_n_oe_n(th_oe_n));
  smbus_host_model i_smbus_host_model (.clk, .sda_wire, .scl, .sda_rel);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // converter stand-in: quarter degrees, done two cycles after start
  always @(negedge clk) begin
    adc_done <= pend[1];
    adc_temp <= adc_remote ? rem_q : loc_q;
    pend     <= {pend[0], adc_start};
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, e);
    i_smbus_host_model.read_reg(a, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rc
  task automatic wr(input logic [7:0] a, d);
    i_smbus_host_model.write_reg(a, d, 1'b1);
  endtask : wr
  // two remote commits, so a full fresh conversion has landed
  task automatic wait_conv();
    int n;
    n = 0;
    for (int k = 0; k < 4000 && n < 2; k++) begin
      @(posedge clk);
      if (adc_done && adc_bias_n2) n++;
    end
    repeat (4) @(negedge clk);
    chk("conversions", 8'h02, 8'(n));
  endtask : wait_conv
  task automatic t_reset();
    rc(8'h03, 8'h00);
    rc(8'h05, 8'h7f);
    rc(8'hfe, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_values();
    wr(8'h04, 8'h08);
    wait_conv();
    rc(8'h00, 8'h19);
    rc(8'h10, 8'h80);
    rc(8'h01, 8'h32);
    $display("value test done");
  endtask : t_values
  task automatic t_lock();
    rc(8'h10, 8'h80);
    rem_q = 13'd241;
    wait_conv();
    rc(8'h10, 8'h40);
    rc(8'h01, 8'h32);
    rc(8'h01, 8'h3c);
    $display("lock test done");
  endtask : t_lock
  // standby freezes the values until a one-shot refreshes them
  task automatic t_shot();
    wr(8'h09, 8'h40);
    rem_q = 13'd150;
    rc(8'h01, 8'h3c);
    wr(8'h0f, 8'h00);
    rc(8'h10, 8'h80);
    rc(8'h01, 8'h25);
    wr(8'h09, 8'h00);
    $display("shot test done");
  endtask : t_shot
  task automatic t_limits();
    wr(8'h05, 8'h14);
    wait_conv();
    chk("alarm", 8'h00, 8'(alarm_oe_n));
    rc(8'h05, 8'h14);
    i_smbus_host_model.read_reg(8'h02, q);
    chk("loc high flag", 8'h40, q & 8'h40);
    wr(8'h09, 8'h80);
    wait_conv();
    chk("alarm masked", 8'h01, 8'(alarm_oe_n));
    wr(8'h20, 8'h10);
    wait_conv();
    chk("thermal", 8'h00, 8'(th_oe_n));
    wr(8'h09, 8'ha0);
    wait_conv();
    chk("second thermal", 8'h00, 8'(alarm_oe_n));
    $display("limit test done");
  endtask : t_limits
  task automatic t_range();
    wr(8'h05, 8'h7f);
    wr(8'h09, 8'h04);
    wait_conv();
    rc(8'h00, 8'h59);
    i_smbus_host_model.read_reg(8'h02, q);
    chk("status", 8'h41, q & 8'h7f);
    wait_conv();
    chk("alarm clear", 8'h01, 8'(alarm_oe_n));
    diode_fault = 1'b1;
    wait_conv();
    chk("fault alarm", 8'h00, 8'(alarm_oe_n));
    $display("range test done");
  endtask : t_range
  task automatic wrap_up();
    chk("host naks", 8'h00, 8'(i_smbus_host_model.nak_cnt));
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    #300000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    diode_fault = 1'b0;
    pend = 2'b00;
    loc_q = 13'd103;
    rem_q = 13'd202;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_values();
    t_lock();
    t_shot();
    t_limits();
    t_range();
    wrap_up();
  end
endmodule : temp_monitor_results_tb_top
